// ===== verilog/pds_top.sv
// Power-down sequencer: seven shutdown-slot registers and the descending stepper.
// Assumes sys_on, pwrdn_start, step_tick and rearm come from logic on core_clk;
// fuse_startup_slot comes from nonvolatile storage and is synchronised here.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pds_cfg.svh"

// Function
// - Seven separate 3-bit shutdown-slot fields
// - Reset loads each slot from startup fuse
// - Disable outputs stepwise, highest slot first
// - Slot writes accepted only in system-on
// - All slots zero: disable everything at once
// - Startup order comes from fuse only
module pds_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`PDS_ADDR_W-1:0] reg_addr,
  input wire logic [`PDS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`PDS_DATA_W-1:0] reg_rdata,
  input wire logic [`PDS_NUM_OUT*`PDS_SLOT_W-1:0] fuse_startup_slot,
  input wire logic sys_on,
  input wire logic pwrdn_start,
  input wire logic step_tick,
  input wire logic rearm,
  output logic [`PDS_NUM_OUT-1:0] out_on,
  output logic [`PDS_NUM_OUT*`PDS_SLOT_W-1:0] startup_slot,
  output logic seq_busy,
  output logic seq_done
);

  localparam int NOUT = `PDS_NUM_OUT;
  localparam int SW = `PDS_SLOT_W;
  localparam int DW = `PDS_DATA_W;

  logic rst_n;

  // Whole state in one register
  pds_pkg::pds_state_s s_q;
  pds_pkg::pds_state_s s_d;

  // Per-output decode and merge
  logic [NOUT-1:0] at_level;
  logic [NOUT-1:0] addr_hit;
  logic [NOUT-1:0] rd_hit;
  logic [NOUT-1:0] wr_hit;
  logic [`PDS_ADDR_W-1:0] ofs [NOUT];
  pds_pkg::pds_slots_t slot_wr;
  logic [SW-1:0] rd_slot;

  // Sequencer conditions
  logic in_idle;
  logic wr_open;
  logic all_zero;
  logic last_level;
  logic fuse_ready;

  // Register offsets in output order
  assign ofs[0] = `PDS_OFS_BUCK1;
  assign ofs[1] = `PDS_OFS_BUCK2;
  assign ofs[2] = `PDS_OFS_BUCK3;
  assign ofs[3] = `PDS_OFS_LINREG1;
  assign ofs[4] = `PDS_OFS_LINREG2;
  assign ofs[5] = `PDS_OFS_LINREG3;
  assign ofs[6] = `PDS_OFS_MEMREF;

  pds_rst_sync u_rst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rst_sync_n(rst_n)
  );

  // Writes land only in idle while the system is on;
  // a start in the same cycle wins so the order is frozen
  assign in_idle = (s_q.st == pds_pkg::PDS_IDLE);
  assign wr_open = reg_wr && sys_on && in_idle && !pwrdn_start;

  // Per-output level match, decode and write merge
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_out
      logic [SW-1:0] cur_slot;
      assign cur_slot = s_q.slot[gi*SW +: SW];
      assign at_level[gi] = (cur_slot == s_q.level);
      assign addr_hit[gi] = (reg_addr == ofs[gi]);
      assign rd_hit[gi] = reg_rd && addr_hit[gi];
      assign wr_hit[gi] = wr_open && addr_hit[gi];
      // Unaddressed slots keep their value
      assign slot_wr[gi*SW +: SW] = wr_hit[gi] ? reg_wdata[`PDS_SLOT_LSB +: SW] : cur_slot;
    end
  endgenerate

  // Readback mux; an unmapped address or no strobe
  // reads as zero
  always_comb begin
    rd_slot = '0;
    for (int i = 0; i < NOUT; i++) begin
      if (rd_hit[i]) begin
        rd_slot = s_q.slot[i*SW +: SW];
      end
    end
  end

  assign all_zero = (s_q.slot == '0);
  assign last_level = (s_q.level == `PDS_SLOT_RST);
  assign fuse_ready = (s_q.init_cnt == `PDS_FUSE_SETTLE);

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-flop capture of the fuse value
    s_d.fuse_s1 = fuse_startup_slot;
    s_d.fuse_s2 = s_q.fuse_s1;
    s_d.done = 1'b0;
    // Read data stand for the cycle after the strobe only
    s_d.rd_data = {{(DW-SW){1'b0}}, rd_slot};

    // Control: state, level, busy and done
    case (s_q.st)
      pds_pkg::PDS_INIT: begin
        if (fuse_ready) begin
          s_d.st = pds_pkg::PDS_IDLE;
        end else begin
          s_d.init_cnt = s_q.init_cnt + 2'h1;
        end
      end

      pds_pkg::PDS_IDLE: begin
        // Start taken only here; later starts are ignored
        if (pwrdn_start && all_zero) begin
          s_d.done = 1'b1;
          s_d.st = pds_pkg::PDS_DONE;
        end else if (pwrdn_start) begin
          // Level counts down from the top slot
          s_d.level = `PDS_SLOT_TOP;
          s_d.busy = 1'b1;
          s_d.st = pds_pkg::PDS_STEP;
        end
      end

      pds_pkg::PDS_STEP: begin
        // Empty levels still use a tick, so timing is fixed
        if (step_tick && last_level) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = pds_pkg::PDS_DONE;
        end else if (step_tick) begin
          s_d.level = s_q.level - 3'h1;
        end
      end

      pds_pkg::PDS_DONE: begin
        // Back to idle, slots unchanged
        if (rearm) begin
          s_d.st = pds_pkg::PDS_IDLE;
        end
      end

      default: begin
        s_d.st = pds_pkg::PDS_IDLE;
      end
    endcase

    // Data: slot registers and output enables
    case (s_q.st)
      pds_pkg::PDS_INIT: begin
        // Outputs stay off until the fuse copy has settled
        if (fuse_ready) begin
          s_d.startup = s_q.fuse_s2;
          s_d.slot = s_q.fuse_s2;
          s_d.out_on = '1;
        end
      end

      pds_pkg::PDS_IDLE: begin
        if (pwrdn_start && all_zero) begin
          // Bypass: every output off in one edge
          s_d.out_on = '0;
        end else if (!pwrdn_start) begin
          s_d.slot = slot_wr;
        end
      end

      pds_pkg::PDS_STEP: begin
        // Outputs at the current level go off together
        if (step_tick) begin
          s_d.out_on = s_q.out_on & ~at_level;
        end
      end

      pds_pkg::PDS_DONE: begin
        // Slots keep the order software left in them
        if (rearm) begin
          s_d.out_on = '1;
        end
      end

      default: begin
        s_d.out_on = '0;
      end
    endcase
  end

  // Reset clears everything; the fuse loads afterwards
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign reg_rdata = s_q.rd_data;
  assign out_on = s_q.out_on;
  assign startup_slot = s_q.startup;
  assign seq_busy = s_q.busy;
  assign seq_done = s_q.done;

endmodule // pds_top

`default_nettype wire

// ===== shared/pds_cfg.svh
// Offsets, field layout, reset values and counts of the power-down sequencer.
// Included by the package and design files; definitions only.
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH

`define PDS_NUM_OUT 7
`define PDS_SLOT_W 3
`define PDS_SLOT_LSB 0
`define PDS_ADDR_W 8
`define PDS_DATA_W 8
`define PDS_OFS_BUCK1 8'h5F
`define PDS_OFS_BUCK2 8'h60
`define PDS_OFS_BUCK3 8'h61
`define PDS_OFS_LINREG1 8'h62
`define PDS_OFS_LINREG2 8'h63
`define PDS_OFS_LINREG3 8'h64
`define PDS_OFS_MEMREF 8'h65
`define PDS_SLOT_RST 3'h0
`define PDS_SLOT_TOP 3'h7
`define PDS_FUSE_SETTLE 2'h2
`define PDS_UNMAPPED_RD 8'h00

`endif

// ===== shared/pds_pkg.sv
// Types of the power-down sequencer.
// Expects pds_cfg.svh on the include path.
`include "pds_cfg.svh"

package pds_pkg;

  typedef enum logic [1:0] {
    PDS_INIT = 2'b00,
    PDS_IDLE = 2'b01,
    PDS_STEP = 2'b10,
    PDS_DONE = 2'b11
  } pds_state_e;

  typedef logic [`PDS_NUM_OUT*`PDS_SLOT_W-1:0] pds_slots_t;

  typedef struct packed {
    pds_slots_t fuse_s1;
    pds_slots_t fuse_s2;
    pds_slots_t startup;
    pds_slots_t slot;
    logic [1:0] init_cnt;
    logic [`PDS_NUM_OUT-1:0] out_on;
    logic [`PDS_SLOT_W-1:0] level;
    pds_state_e st;
    logic [`PDS_DATA_W-1:0] rd_data;
    logic busy;
    logic done;
  } pds_state_s;

endpackage

// ===== verilog/pds_rst_sync.sv
// Reset release synchroniser: asynchronous assert, two-flop release.
// Assumes reset_n comes from a pin outside the core_clk domain.
`timescale 1ns/1ps
`default_nettype none

module pds_rst_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic rst_sync_n
);

  logic stage1_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      rst_sync_n <= stage1_q;
    end
  end

endmodule // pds_rst_sync

`default_nettype wire

// ===== bench/pds_assertions.sv
// Checker on the pds_top ports.
// Bound below; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pds_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pwrdn_start,
  input wire logic step_tick,
  input wire logic [6:0] out_on,
  input wire logic seq_busy,
  input wire logic seq_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_go;
    pwrdn_start && !seq_busy && &out_on;
  endsequence
  a_rd_bits: assert property (reg_rd |=> !reg_rdata[7:3]) else $error("rd");
  a_rd_quiet: assert property (!reg_rd |=> !reg_rdata) else $error("rd");
  a_go_path: assert property (s_go |=> seq_busy || seq_done && !out_on) else $error("go");
  a_only_off: assert property (seq_busy |=> !(out_on & ~$past(out_on))) else $error("on");
  a_tick_step: assert property (seq_busy && !step_tick |=> $stable(out_on)) else $error("tick");
  a_end_off: assert property ($fell(seq_busy) |-> seq_done && !out_on) else $error("end");
  a_done_once: assert property (seq_done |=> !seq_done) else $error("done");
endmodule // pds_checker
bind pds_top pds_checker i_chk (.*);
`default_nettype wire

// ===== bench/test_power_down_sequencer.sv
// Bench of the power-down sequencer.
// Drives pds_top alone; checker is bound.
`timescale 1ns/1ps
`default_nettype none
module test_power_down_sequencer;
  logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, sys_on = 0, rp = 0, tp = 0;
  logic pwrdn_start = 0, step_tick = 0, rearm = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, q[$];
  logic [20:0] fuse_startup_slot = 0, sl, startup_slot;
  logic [6:0] out_on;
  logic seq_busy, seq_done;
  logic [1:0] qf[$];
  int error_cnt = 0, compares = 0;
  always #4 core_clk = ~core_clk;
  pds_top i_dut (.*);
  task tally_and_finish;
    if (!error_cnt && compares) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(string n, logic [7:0] x, y);
    compares++;
    if (x !== y) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, x, y);
    end
  endtask
  task cmp_flags(logic [1:0] x, y);
    compares++;
    if (x !== y) begin
      error_cnt++;
      $display("mismatch seq_busy_done exp %h got %h", x, y);
    end
  endtask
  task cmp_start(logic [20:0] x, y);
    compares++;
    if (x !== y) begin
      error_cnt++;
      $display("mismatch startup_slot exp %h got %h", x, y);
    end
  endtask
  always @(posedge core_clk) begin
    if (rp | tp) cmp(rp ? "reg_rdata" : "out_on", q.pop_front(), rp ? reg_rdata : {1'b0, out_on});
    if (tp) cmp_flags(qf.pop_front(), {seq_busy, seq_done});
    rp <= reg_rd;
    tp <= pwrdn_start | step_tick | rearm;
  end
  task op(logic [5:0] k, logic [7:0] a = 0, v = 0);
    @(posedge core_clk);
    {sys_on, rearm, step_tick, pwrdn_start, reg_rd, reg_wr, reg_addr, reg_wdata} <= {k ^ 6'h20, a, v};
  endtask
  // m: 0 read, 1 random, 2 zero, 3 with system off
  task sweep(int m);
    for (int i = 0; i < 8; i++) begin
      d = m == 2 ? 8'hF8 : 8'($urandom);
      if (!m) q.push_back(i < 7 ? {5'h00, sl[i*3+:3]} : 8'h00);
      else if (m < 3 && i < 7) sl[i*3+:3] = d[2:0];
      op(!m ? 6'h02 : m == 3 ? 6'h21 : 6'h01, 8'h5F + 8'(i), d);
    end
  endtask
  task pd;
    d = 8'h7F;
    q.push_back(sl ? d : 8'h00);
    qf.push_back(sl ? 2'b10 : 2'b01);
    op(6'h04);
    for (int l = 7; l >= 0 && sl; l--) begin
      op(6'h08);
      for (int j = 0; j < 7; j++) if (sl[j*3+:3] == 3'(l)) d[j] = 0;
      q.push_back(d);
      qf.push_back(l ? 2'b10 : 2'b01);
    end
    q.push_back(8'h7F);
    qf.push_back(2'b00);
    op(6'h10);
  endtask
  initial begin
    void'($urandom(32'h0fc01b0b));
    fuse_startup_slot <= 21'($urandom);
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    repeat (8) op(6'h00);
    sl = fuse_startup_slot;
    sweep(3);
    sweep(0);
    sweep(1);
    sweep(0);
    cmp_start(fuse_startup_slot, startup_slot);
    pd();
    sweep(2);
    pd();
    repeat (3) op(6'h00);
    reset_n <= 0;
    repeat (2) op(6'h00);
    reset_n <= 1;
    repeat (8) op(6'h00);
    sl = fuse_startup_slot;
    sweep(0);
    repeat (2) op(6'h00);
    tally_and_finish;
  end
  // Hang guard, far beyond the run
  initial begin
    #20us;
    error_cnt++;
    tally_and_finish;
  end
endmodule // test_power_down_sequencer
`default_nettype wire
